/* logic/dpc_map.vh */
// Purpose: constants for the dancer-roll pid controller (register map, codes, timing)
// Assumes: apb with 32-bit data, word-aligned registers
// Notes: settings use the drive's parameter units (0.1 %, 0.1 s, 0.01 s)
//
// Function
// - dancer enable routes selected terminals to dancer functions over other roles; the terminal-4 taper role still beats a dancer select of terminal 4
// - terminal-4 taper role beats taper source selection
// - tension control (6 or 16) ignores dancer signal, main speed, tension selects
// - shared terminal feeds only highest-priority function, others see zero
// - dancer control and diameter compensation only while dancer enable asserted
// - diameter frozen when hold and enable both on, or calc setting is 9999
// - enable and hold inputs mapped to terminals by function codes 83 and 84
// - action select 40 reverse (default), 41 forward; dancer signal default terminal 1
// - output is G times Kp times (1 + 1/(Ti s) + Td s), Kp = 1/band
// - integral term clamped to a level between 0 and 100 percent
// - 9999 clamp means 100 percent; positive alone applies to both polarities
// - negative deviation uses the under-set-point gain set
// - an under-set-point gain holding 9999 falls back to the normal gain
// - diameter calculation only above activation speed, default 3 Hz
// - target 500 percent is 0, 600 is +100, 400 is -100, linear
`ifndef DPC_MAP_VH
`define DPC_MAP_VH
// register byte offsets
`define DPC_REG_CTRL      8'h00
`define DPC_REG_SRC       8'h04
`define DPC_REG_ROLE      8'h08
`define DPC_REG_TARGET    8'h0c
`define DPC_REG_PBAND     8'h10
`define DPC_REG_ITIME     8'h14
`define DPC_REG_DTIME     8'h18
`define DPC_REG_UPBAND    8'h1c
`define DPC_REG_UITIME    8'h20
`define DPC_REG_UDTIME    8'h24
`define DPC_REG_CLAMP     8'h28
`define DPC_REG_DIAM      8'h2c
`define DPC_REG_GAIN      8'h30
`define DPC_REG_STATUS    8'h34
`define DPC_REG_OUT       8'h38
`define DPC_REG_XFUNC     8'h3c
// codes and reset values
`define DPC_NONE          16'h270f
`define DPC_ACT_REV       8'h28
`define DPC_ACT_FWD       8'h29
`define DPC_TENS_A        8'h06
`define DPC_TENS_B        8'h10
`define DPC_FN_ENABLE     8'h53
`define DPC_FN_HOLD       8'h54
`define DPC_T4_TAPER      8'h02
`define DPC_SEL_T2        3'h3
`define DPC_SEL_T4        3'h4
`define DPC_SEL_T1        3'h5
`define DPC_SEL_T6        3'h6
`define DPC_SRC_RST       15'h2b6d
`define DPC_TARGET_RST    16'h1388
`define DPC_TARGET_ZERO   16'h1388
`define DPC_PBAND_RST     16'h03e8
`define DPC_ITIME_RST     16'h000a
`define DPC_ACT_SPD_RST   16'h012c
`define DPC_PERIOD_US     1000
`define DPC_CLK_MHZ       20
`define DPC_PERIOD_CYC    (`DPC_PERIOD_US * `DPC_CLK_MHZ)
`endif

/* logic/dpc_controller.v */
// Purpose: dancer-roll position pid controller with terminal routing and apb settings
// Assumes: analog samples arrive as signed 16-bit percent*100 (10000 = 100 %)
// Notes: one clock; control period is a parameter so simulation can shorten it
`include "dpc_map.vh"
`timescale 1ns/10ps
`default_nettype none
module dpc_controller #(
  parameter PERIOD_CYC = `DPC_PERIOD_CYC  // cycles per pid update
) (
  input  wire        clk_sys_in,        // 20 mhz clock
  input  wire        sys_rst_in,        // async reset, high
  input  wire        psel_in,           // apb select
  input  wire        penable_in,        // apb enable
  input  wire        pwrite_in,         // apb write
  input  wire [7:0]  paddr_in,          // apb byte address
  input  wire [31:0] pwdata_in,         // apb write data
  output reg  [31:0] prdata_out,        // apb read data
  output reg         pready_out,        // apb ready
  output reg         pslverr_out,       // apb error, unmapped address
  input  wire [11:0] term_in,           // discrete input terminals (async)
  input  wire [15:0] ain_t1_in,         // terminal 1 sample
  input  wire [15:0] ain_t2_in,         // terminal 2 sample
  input  wire [15:0] ain_t4_in,         // terminal 4 sample
  input  wire [15:0] ain_t6_in,         // terminal 6 sample
  input  wire [15:0] motor_speed_in,    // rotation speed, 0.01 hz
  output reg  [15:0] pid_out,           // pid compensation, signed
  output reg  [15:0] main_speed_out,    // routed main speed
  output reg  [15:0] line_speed_out,    // routed line speed
  output reg  [15:0] taper_out,         // routed taper
  output reg  [15:0] tension_out,       // routed tension reference
  output reg         diam_calc_en_out,  // diameter calculation may run
  output reg         dancer_active_out  // dancer control running
);
  //----------------------------------------------------------------
  // settings registers
  //----------------------------------------------------------------
  reg [7:0]  ctrl_action_ff;   // pid_action_sel
  reg [7:0]  ctrl_method_ff;   // control_method_sel
  reg [14:0] src_ff;           // 5 x 3-bit selects: dancer,main,taper,tension,line
  reg [7:0]  t4_role_ff;       // terminal_four_role_sel
  reg [15:0] target_ff;        // target_position_setting, 0.1 %
  reg [15:0] pband_ff;
  reg [15:0] itime_ff;
  reg [15:0] dtime_ff;
  reg [15:0] upband_ff;
  reg [15:0] uitime_ff;
  reg [15:0] udtime_ff;
  reg [15:0] clamp_pos_ff;
  reg [15:0] clamp_neg_ff;
  reg [15:0] diam_set_ff;      // diameter_calc_setting
  reg [15:0] act_spd_ff;       // diameter_calc_activation_speed
  reg [15:0] gain_ff;          // g, 8.8 fixed point
  reg [95:0] xfunc_ff;         // input_terminal_function_sel, 8 bits per terminal
  //----------------------------------------------------------------
  // discrete input synchroniser and function mapping
  //----------------------------------------------------------------
  reg [11:0] term_s1_ff;
  reg [11:0] term_s2_ff;
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      term_s1_ff <= 12'h000;
      term_s2_ff <= 12'h000;
    end
    else
    begin
      term_s1_ff <= term_in;
      term_s2_ff <= term_s1_ff;
    end
  end
  // a terminal drives enable or hold when its function code says so
  wire [11:0] en_hit;
  wire [11:0] hold_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1)
    begin : g_term
      assign en_hit[gi]   = term_s2_ff[gi] && (xfunc_ff[gi*8 +: 8] == `DPC_FN_ENABLE);
      assign hold_hit[gi] = term_s2_ff[gi] && (xfunc_ff[gi*8 +: 8] == `DPC_FN_HOLD);
    end
  endgenerate
  wire dancer_en  = |en_hit;
  wire diam_hold  = |hold_hit;
  wire tension_md = (ctrl_method_ff == `DPC_TENS_A) || (ctrl_method_ff == `DPC_TENS_B);
  //----------------------------------------------------------------
  // terminal routing with priority
  //----------------------------------------------------------------
  function [15:0] pick;
    input [2:0] sel;
    begin
      case (sel)
        `DPC_SEL_T2: pick = ain_t2_in;
        `DPC_SEL_T4: pick = ain_t4_in;
        `DPC_SEL_T1: pick = ain_t1_in;
        `DPC_SEL_T6: pick = ain_t6_in;
        default:     pick = 16'h0000;
      endcase
    end
  endfunction
  wire [2:0] sel_dan = src_ff[2:0];
  wire [2:0] sel_mai = src_ff[5:3];
  wire [2:0] sel_tap = src_ff[8:6];
  wire [2:0] sel_ten = src_ff[11:9];
  wire [2:0] sel_lin = src_ff[14:12];
  wire t4_taper = (t4_role_ff == `DPC_T4_TAPER);
  // effective selects; tension mode drops dancer, main and tension choices
  wire [2:0] e_dan = (dancer_en && !tension_md) ? sel_dan : 3'h0;
  wire [2:0] e_mai = (dancer_en && !tension_md) ? sel_mai : 3'h0;
  wire [2:0] e_ten = (dancer_en && !tension_md) ? sel_ten : 3'h0;
  wire [2:0] e_lin = dancer_en ? sel_lin : 3'h0;
  wire [2:0] e_tap = t4_taper ? `DPC_SEL_T4 : (dancer_en ? sel_tap : 3'h0);
  // lower-priority function sees zero when a higher one owns the terminal
  wire own_dan = (e_dan != 3'h0) && !(t4_taper && e_dan == `DPC_SEL_T4);
  wire own_lin = (e_lin != 3'h0) && !(t4_taper && e_lin == `DPC_SEL_T4)
                 && !(own_dan && e_lin == e_dan);
  wire own_mai = (e_mai != 3'h0) && !(t4_taper && e_mai == `DPC_SEL_T4)
                 && !(own_dan && e_mai == e_dan) && !(own_lin && e_mai == e_lin);
  wire own_tap = (e_tap != 3'h0) && (t4_taper
                 || (!(own_dan && e_tap == e_dan) && !(own_lin && e_tap == e_lin)
                 && !(own_mai && e_tap == e_mai)));
  wire own_ten = (e_ten != 3'h0) && !(e_ten == e_tap && own_tap)
                 && !(own_dan && e_ten == e_dan) && !(own_lin && e_ten == e_lin)
                 && !(own_mai && e_ten == e_mai);
  wire [15:0] dancer_sig = own_dan ? pick(e_dan) : 16'h0000;
  //----------------------------------------------------------------
  // gain selection
  //----------------------------------------------------------------
  // set point: (target - 500 %) scaled so 100 % step = 10000
  wire signed [17:0] sp_full = $signed({2'b00, target_ff}) - $signed({2'b00, `DPC_TARGET_ZERO});
  wire signed [17:0] sp      = sp_full * 18'sd10;
  wire signed [17:0] dev_raw = $signed({{2{dancer_sig[15]}}, dancer_sig}) - sp;
  wire neg_dev = dev_raw[17];
  wire [15:0] pb_eff = (neg_dev && upband_ff != `DPC_NONE) ? upband_ff : pband_ff;
  wire [15:0] ti_eff = (neg_dev && uitime_ff != `DPC_NONE) ? uitime_ff : itime_ff;
  wire [15:0] td_eff = (neg_dev && udtime_ff != `DPC_NONE) ? udtime_ff : dtime_ff;
  // clamp levels in the 10000 = 100 % scale, settings are 0.1 % units
  wire [15:0] cp_set = (clamp_pos_ff == `DPC_NONE) ? 16'h03e8 : clamp_pos_ff;
  wire [15:0] cn_set = (clamp_neg_ff == `DPC_NONE) ? cp_set : clamp_neg_ff;
  wire signed [31:0] clamp_p = $signed({16'h0000, cp_set}) * 32'sd10;
  wire signed [31:0] clamp_n = -($signed({16'h0000, cn_set}) * 32'sd10);
  // forward action flips the deviation sign
  wire signed [31:0] dev = (ctrl_action_ff == `DPC_ACT_FWD) ?
                           -{{14{dev_raw[17]}}, dev_raw} : {{14{dev_raw[17]}}, dev_raw};
  //----------------------------------------------------------------
  // control period tick
  //----------------------------------------------------------------
  reg [31:0] tick_cnt_ff;
  wire       tick = (tick_cnt_ff == PERIOD_CYC - 1);
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      tick_cnt_ff <= 32'h0;
    else
      tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
  end
  //----------------------------------------------------------------
  // pid arithmetic; divides kept simple, one result per period
  //----------------------------------------------------------------
  reg  signed [31:0] integ_ff;
  reg  signed [31:0] prev_dev_ff;
  wire pid_run = dancer_en && !tension_md;
  // integral step: dev * period(0.1 s units ~ 1 ms = 1/100) / ti
  wire signed [31:0] i_step = (ti_eff == 16'h0) ? 32'sd0 : dev / ($signed({16'h0, ti_eff}) * 32'sd100);
  wire signed [31:0] i_sum  = integ_ff + i_step;
  wire signed [31:0] i_cl   = (i_sum > clamp_p) ? clamp_p : ((i_sum < clamp_n) ? clamp_n : i_sum);
  // derivative: td(0.01 s) / period(1 ms) = td * 10
  // a differential time of 9999 means no d action, else it would swamp the loop
  wire [15:0] td_use = (td_eff == `DPC_NONE) ? 16'h0000 : td_eff;
  wire signed [31:0] d_term = (dev - prev_dev_ff) * $signed({16'h0, td_use}) * 32'sd10;
  // kp = 1000 / band(0.1 %), g in 8.8 fixed point
  wire signed [31:0] mix    = dev + i_cl + d_term;
  wire signed [31:0] kp_out = (pb_eff == 16'h0) ? 32'sd0 : (mix * 32'sd1000) / $signed({16'h0, pb_eff});
  wire signed [31:0] g_out  = (kp_out * $signed({16'h0, gain_ff})) >>> 8;
  wire signed [31:0] sat    = (g_out > 32'sd32767) ? 32'sd32767 :
                              ((g_out < -32'sd32768) ? -32'sd32768 : g_out);
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      integ_ff    <= 32'sd0;
      prev_dev_ff <= 32'sd0;
      pid_out     <= 16'h0000;
    end
    else if (!pid_run)
    begin
      integ_ff    <= 32'sd0;
      prev_dev_ff <= 32'sd0;
      pid_out     <= 16'h0000;
    end
    else if (tick)
    begin
      integ_ff    <= i_cl;
      prev_dev_ff <= dev;
      pid_out     <= sat[15:0];
    end
  end
  //----------------------------------------------------------------
  // routed outputs and diameter enable
  //----------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      main_speed_out    <= 16'h0000;
      line_speed_out    <= 16'h0000;
      taper_out         <= 16'h0000;
      tension_out       <= 16'h0000;
      diam_calc_en_out  <= 1'b0;
      dancer_active_out <= 1'b0;
    end
    else
    begin
      main_speed_out    <= own_mai ? pick(e_mai) : 16'h0000;
      line_speed_out    <= own_lin ? pick(e_lin) : 16'h0000;
      taper_out         <= own_tap ? pick(e_tap) : 16'h0000;
      tension_out       <= own_ten ? pick(e_ten) : 16'h0000;
      // frozen diameter on hold, 9999 setting, or at or below activation speed
      diam_calc_en_out  <= pid_run && !diam_hold && (diam_set_ff != `DPC_NONE)
                           && (motor_speed_in > act_spd_ff);
      dancer_active_out <= pid_run;
    end
  end
  //----------------------------------------------------------------
  // apb slave, zero wait states
  //----------------------------------------------------------------
  wire wr = psel_in && penable_in && pwrite_in;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;
  always @*
  begin
    nxt_err = 1'b0;
    case (paddr_in)
      `DPC_REG_CTRL:   nxt_rdata = {16'h0, ctrl_method_ff, ctrl_action_ff};
      `DPC_REG_SRC:    nxt_rdata = {17'h0, src_ff};
      `DPC_REG_ROLE:   nxt_rdata = {24'h0, t4_role_ff};
      `DPC_REG_TARGET: nxt_rdata = {16'h0, target_ff};
      `DPC_REG_PBAND:  nxt_rdata = {16'h0, pband_ff};
      `DPC_REG_ITIME:  nxt_rdata = {16'h0, itime_ff};
      `DPC_REG_DTIME:  nxt_rdata = {16'h0, dtime_ff};
      `DPC_REG_UPBAND: nxt_rdata = {16'h0, upband_ff};
      `DPC_REG_UITIME: nxt_rdata = {16'h0, uitime_ff};
      `DPC_REG_UDTIME: nxt_rdata = {16'h0, udtime_ff};
      `DPC_REG_CLAMP:  nxt_rdata = {clamp_neg_ff, clamp_pos_ff};
      `DPC_REG_DIAM:   nxt_rdata = {act_spd_ff, diam_set_ff};
      `DPC_REG_GAIN:   nxt_rdata = {16'h0, gain_ff};
      `DPC_REG_STATUS: nxt_rdata = {27'h0, neg_dev, tension_md, diam_hold, dancer_en, pid_run};
      `DPC_REG_OUT:    nxt_rdata = {16'h0, pid_out};
      `DPC_REG_XFUNC:  nxt_rdata = 32'h0;   // terminal codes written here: [15:8] index, [7:0] code
      default:
      begin
        nxt_rdata = 32'h0;
        nxt_err   = 1'b1;
      end
    endcase
  end
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      prdata_out     <= 32'h0;
      pready_out     <= 1'b0;
      pslverr_out    <= 1'b0;
      ctrl_action_ff <= `DPC_ACT_REV;
      ctrl_method_ff <= 8'h00;
      src_ff         <= `DPC_SRC_RST;     // dancer on terminal 1
      t4_role_ff     <= 8'h00;
      target_ff      <= `DPC_TARGET_RST;
      pband_ff       <= `DPC_PBAND_RST;
      itime_ff       <= `DPC_ITIME_RST;
      dtime_ff       <= `DPC_NONE;
      upband_ff      <= `DPC_NONE;
      uitime_ff      <= `DPC_NONE;
      udtime_ff      <= `DPC_NONE;
      clamp_pos_ff   <= `DPC_NONE;
      clamp_neg_ff   <= `DPC_NONE;
      diam_set_ff    <= `DPC_NONE;
      act_spd_ff     <= `DPC_ACT_SPD_RST;
      gain_ff        <= 16'h0100;
      xfunc_ff       <= 96'h0;
    end
    else
    begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && nxt_err;
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? nxt_rdata : 32'h0;
      if (wr && !nxt_err)
      begin
        case (paddr_in)
          `DPC_REG_CTRL:   {ctrl_method_ff, ctrl_action_ff} <= pwdata_in[15:0];
          `DPC_REG_SRC:    src_ff     <= pwdata_in[14:0];
          `DPC_REG_ROLE:   t4_role_ff <= pwdata_in[7:0];
          `DPC_REG_TARGET: target_ff  <= pwdata_in[15:0];
          `DPC_REG_PBAND:  pband_ff   <= pwdata_in[15:0];
          `DPC_REG_ITIME:  itime_ff   <= pwdata_in[15:0];
          `DPC_REG_DTIME:  dtime_ff   <= pwdata_in[15:0];
          `DPC_REG_UPBAND: upband_ff  <= pwdata_in[15:0];
          `DPC_REG_UITIME: uitime_ff  <= pwdata_in[15:0];
          `DPC_REG_UDTIME: udtime_ff  <= pwdata_in[15:0];
          `DPC_REG_CLAMP:  {clamp_neg_ff, clamp_pos_ff} <= pwdata_in;
          `DPC_REG_DIAM:   {act_spd_ff, diam_set_ff}    <= pwdata_in;
          `DPC_REG_GAIN:   gain_ff    <= pwdata_in[15:0];
          `DPC_REG_XFUNC:  if (pwdata_in[15:8] < 8'd12)
                             xfunc_ff[pwdata_in[11:8]*8 +: 8] <= pwdata_in[7:0];
          default:         gain_ff    <= gain_ff;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* test/dpc_controller_chk.sv */
// Purpose: port-level assertions for the dancer pid controller
// Assumes: bound to every dpc_controller instance; control period above 8 cycles
// Notes: main, line and tension outputs are compared with the samples of the cycle before
`timescale 1ns/10ps
`default_nettype none
module dpc_controller_chk (
  input wire logic        clk_sys_in,        // clock
  input wire logic        sys_rst_in,        // async reset, high
  input wire logic        psel_in,           // apb select
  input wire logic        penable_in,        // apb enable
  input wire logic [31:0] prdata_out,        // apb read data
  input wire logic        pready_out,        // apb ready
  input wire logic        pslverr_out,       // apb error
  input wire logic [15:0] ain_t1_in,         // terminal 1
  input wire logic [15:0] ain_t2_in,         // terminal 2
  input wire logic [15:0] ain_t4_in,         // terminal 4
  input wire logic [15:0] ain_t6_in,         // terminal 6
  input wire logic [15:0] motor_speed_in,    // speed
  input wire logic [15:0] pid_out,           // pid output
  input wire logic [15:0] main_speed_out,    // routed main speed
  input wire logic [15:0] line_speed_out,    // routed line speed
  input wire logic [15:0] tension_out,       // routed tension
  input wire logic        diam_calc_en_out,  // diameter calc allowed
  input wire logic        dancer_active_out  // dancer running
);
  logic [15:0] q1_ff, q2_ff, q4_ff, q6_ff;
  // routing is one register deep, so a routed value must be last cycle's sample or zero
  always_ff @(posedge clk_sys_in)
  begin
    {q1_ff, q2_ff, q4_ff, q6_ff} <= {ain_t1_in, ain_t2_in, ain_t4_in, ain_t6_in};
  end
  function automatic logic from_term(input logic [15:0] v);
    return v == 16'h0 || v == q1_ff || v == q2_ff || v == q4_ff || v == q6_ff;
  endfunction
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  bus_answer_a: // zero wait states
    assert property (psel_in && !penable_in |=> pready_out) else $error("no ready after setup");
  bus_refuse_a: // refused access reads zero
    assert property (pslverr_out |-> pready_out && prdata_out == 32'h0) else $error("bad refusal");
  pid_idle_a:
    assert property (!dancer_active_out [*3] |-> pid_out == 16'h0) else $error("pid not zero when idle");
  pid_period_a:
    assert property (dancer_active_out && $past(dancer_active_out) && $changed(pid_out) |=>
      ($stable(pid_out) || !dancer_active_out) [*8]) else $error("pid updated too often");
  pid_start_a:
    assert property (pid_out != 16'h0 && $past(pid_out) == 16'h0 |-> dancer_active_out)
      else $error("pid moved while disabled");
  main_src_a:
    assert property (from_term(main_speed_out)) else $error("main speed not a terminal sample");
  line_src_a:
    assert property (from_term(line_speed_out)) else $error("line speed not a terminal sample");
  tens_src_a:
    assert property (from_term(tension_out)) else $error("tension not a terminal sample");
  diam_speed_a:
    assert property (motor_speed_in == 16'h0 [*3] |-> !diam_calc_en_out) else $error("diam calc at standstill");
endmodule
bind dpc_controller dpc_controller_chk dpc_controller_chk_inst (.*);
`default_nettype wire

/* test/dpc_sensor_model.sv */
// Purpose: dancer position sensor, analog references and motor shaft model
// Assumes: samples refresh every cycle; slew of zero makes the speed jump
// Notes: speed only ramps upward, a drop is taken at once
`timescale 1ns/10ps
`default_nettype none
module dpc_sensor_model (
  input  wire logic        clk_sys_in, // control clock
  input  wire logic [63:0] lvl_in,     // wanted samples t6,t4,t2,t1
  input  wire logic [15:0] spd_in,     // wanted speed, 0.01 hz
  input  wire logic [15:0] slew_in,    // speed step a cycle
  output logic      [15:0] t1_out,     // terminal 1 sample
  output logic      [15:0] t2_out,     // terminal 2 sample
  output logic      [15:0] t4_out,     // terminal 4 sample
  output logic      [15:0] t6_out,     // terminal 6 sample
  output logic      [15:0] spd_out     // shaft speed
);
  // a loaded shaft cannot jump up; a ramp crosses the speed threshold
  always @(posedge clk_sys_in)
  begin
    {t6_out, t4_out, t2_out, t1_out} <= lvl_in;
    if (slew_in == 16'h0 || spd_out >= spd_in || spd_in - spd_out <= slew_in)
      spd_out <= spd_in;
    else
      spd_out <= spd_out + slew_in;
  end
endmodule
`default_nettype wire

/* test/dpc_controller_bench.sv */
// Purpose: self-checking bench for the dancer pid controller
// Assumes: control period shortened to 20 cycles
// Notes: pid values are compared between runs, not against absolute gains
`include "dpc_map.vh"
`timescale 1ns/10ps
`default_nettype none
module dpc_controller_bench;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [7:0]  paddr_in   = 8'h00;
  logic [31:0] pwdata_in  = 32'h0;
  logic [11:0] term_in    = 12'h000;
  logic [63:0] lvl        = 64'h0;
  logic [15:0] spd        = 16'h0;
  logic [15:0] slew       = 16'h0;
  logic [15:0] ain_t1_in, ain_t2_in, ain_t4_in, ain_t6_in, motor_speed_in;
  logic [15:0] pid_out, main_speed_out, line_speed_out, taper_out, tension_out;
  logic [31:0] prdata_out, rd_q;
  logic        pready_out, pslverr_out, err_q, diam_calc_en_out, dancer_active_out;
  int          err_total = 0;
  int          tests_run = 0;
  dpc_controller #(.PERIOD_CYC(20)) dpc_controller_inst (.*);
  dpc_sensor_model dpc_sensor_model_inst (
    .clk_sys_in(clk_sys_in), .lvl_in(lvl), .spd_in(spd), .slew_in(slew), .t1_out(ain_t1_in),
    .t2_out(ain_t2_in), .t4_out(ain_t4_in), .t6_out(ain_t6_in), .spd_out(motor_speed_in));
  // 20 mhz clock
  always #25 clk_sys_in = ~clk_sys_in;
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    if (n >= 20)
      err_total++;
    rd_q = prdata_out;
    err_q = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_q, exp);
  endtask
  function automatic logic [31:0] src(input logic [2:0] d, m, ta, te, l);
    return {17'h0, l, te, ta, m, d};
  endfunction
  function automatic logic near(input logic [15:0] x, input logic [15:0] y);
    logic signed [16:0] df;
    df = $signed({x[15], x}) - $signed({y[15], y});
    return df >= -1 && df <= 1;
  endfunction
  function automatic logic [15:0] abs16(input logic [15:0] x);
    return x[15] ? -x : x;
  endfunction
  // restart the loop so each run starts from its first update
  task automatic first_pid(output logic [15:0] v);
    int n;
    term_in <= 12'h000;
    cyc(6);
    term_in <= 12'h008;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (pid_out === 16'h0 && n < 200);
    v = pid_out;
    if (n >= 200)
      err_total++;
  endtask
  task automatic t_regs();
    rdc("target", `DPC_REG_TARGET, 32'h1388);
    rdc("pband", `DPC_REG_PBAND, 32'h03e8);
    rdc("upband", `DPC_REG_UPBAND, 32'h270f);
    rdc("udtime", `DPC_REG_UDTIME, 32'h270f);
    rdc("diam", `DPC_REG_DIAM, 32'h012c270f);
    apb(1'b0, `DPC_REG_CTRL, 32'h0);
    chk("action", {24'h0, rd_q[7:0]}, 32'h28);
    rdc("unmapped", 8'h40, 32'h0);
    chk("slverr", {31'h0, err_q}, 32'h1);
  endtask
  task automatic t_map();
    wr(`DPC_REG_CTRL, 32'h0028);
    wr(`DPC_REG_XFUNC, {16'h0, 8'h03, `DPC_FN_ENABLE});
    wr(`DPC_REG_XFUNC, {16'h0, 8'h05, `DPC_FN_HOLD});
    rdc("xfunc", `DPC_REG_XFUNC, 32'h0);
    term_in <= 12'h020;
    cyc(6);
    chk("hold only", {31'h0, dancer_active_out}, 32'h0);
    term_in <= 12'h008;
    cyc(6);
    chk("enabled", {31'h0, dancer_active_out}, 32'h1);
  endtask
  // e holds expected main, line, taper, tension
  task automatic route(input logic [31:0] s, input logic [31:0] r, input logic [63:0] e);
    wr(`DPC_REG_SRC, s);
    wr(`DPC_REG_ROLE, r);
    cyc(4);
    chk("main", {16'h0, main_speed_out}, {16'h0, e[63:48]});
    chk("line", {16'h0, line_speed_out}, {16'h0, e[47:32]});
    chk("taper", {16'h0, taper_out}, {16'h0, e[31:16]});
    chk("tension", {16'h0, tension_out}, {16'h0, e[15:0]});
  endtask
  task automatic t_route();
    lvl <= {16'h0666, 16'h0444, 16'h0222, 16'h0111};
    route(src(3'h5, 3'h5, 3'h4, 3'h6, 3'h3), 32'h0, 64'h0000_0222_0444_0666);
    route(src(3'h5, 3'h3, 3'h3, 3'h4, 3'h3), 32'h2, 64'h0000_0222_0444_0000);
    route(src(3'h4, 3'h6, 3'h4, 3'h6, 3'h4), 32'h0, 64'h0666_0000_0000_0000);
  endtask
  task automatic t_mode();
    for (int i = 0; i < 2; i++)
    begin
      wr(`DPC_REG_CTRL, {16'h0, i ? `DPC_TENS_B : `DPC_TENS_A, 8'h28});
      cyc(4);
      chk("tension mode", {31'h0, dancer_active_out}, 32'h0);
      chk("pid off", {16'h0, pid_out}, 32'h0);
    end
    wr(`DPC_REG_CTRL, 32'h0028);
  endtask
  task automatic t_diam();
    wr(`DPC_REG_DIAM, 32'h012c_0064);
    {spd, slew} <= {16'd301, 16'h1};
    cyc(320);
    chk("above", {31'h0, diam_calc_en_out}, 32'h1);
    {spd, slew} <= {16'd300, 16'h0};
    cyc(4);
    chk("at threshold", {31'h0, diam_calc_en_out}, 32'h0);
    spd <= 16'd301;
    term_in <= 12'h028;
    cyc(6);
    chk("held", {31'h0, diam_calc_en_out}, 32'h0);
    term_in <= 12'h008;
    wr(`DPC_REG_DIAM, 32'h012c_270f);
    cyc(4);
    chk("no calc", {31'h0, diam_calc_en_out}, 32'h0);
    wr(`DPC_REG_DIAM, 32'h012c_0064);
    term_in <= 12'h000;
    cyc(6);
    chk("disabled", {31'h0, diam_calc_en_out}, 32'h0);
    spd <= 16'h0;
  endtask
  task automatic t_pid();
    logic [15:0] a, b, c, d, e;
    wr(`DPC_REG_SRC, src(3'h5, 3'h0, 3'h0, 3'h0, 3'h0));
    lvl <= {48'h0, 16'h0064};
    first_pid(a);
    wr(`DPC_REG_CTRL, 32'h0029);
    first_pid(b);
    chk("forward", {31'h0, near(b, -a)}, 32'h1);
    chk("nonzero", {31'h0, a !== 16'h0}, 32'h1);
    wr(`DPC_REG_CTRL, 32'h0028);
    wr(`DPC_REG_UPBAND, 32'h0064);
    first_pid(c);
    chk("over sp", {16'h0, c}, {16'h0, a});
    lvl <= {48'h0, 16'hff9c};
    first_pid(d);
    wr(`DPC_REG_UPBAND, 32'h270f);
    first_pid(e);
    chk("fallback", {31'h0, near(e, -a)}, 32'h1);
    chk("under sp", {31'h0, abs16(d) > abs16(e)}, 32'h1);
    wr(`DPC_REG_TARGET, 32'h13ec);
    lvl <= {48'h0, 16'h044c};
    first_pid(c);
    chk("target", {31'h0, near(c, a)}, 32'h1);
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_map();
    t_route();
    t_mode();
    t_diam();
    t_pid();
    end_sim();
  end
  // about 650 cycles are needed; wide margin
  initial
  begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
